//--- rtcca_pkg.sv
// package of constants and types for the clock calibration and alarm block
`default_nettype none
package rtcca_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_TRIM = 8'h00;
   localparam logic [7:0] ADDR_CFG = 8'h04;
   localparam logic [7:0] ADDR_RPT = 8'h08;
   localparam logic [7:0] ADDR_PTR = 8'h0C;
   localparam logic [7:0] ADDR_WIN = 8'h10;
   localparam logic [7:0] ADDR_TIME0 = 8'h14;
   localparam logic [7:0] ADDR_TIME1 = 8'h18;
   localparam logic [7:0] ADDR_TIME2 = 8'h1C;
   localparam logic [7:0] ADDR_STAT = 8'h20;
   localparam logic [7:0] ADDR_MASK = 8'h24;
   localparam logic [7:0] ADDR_CTRL = 8'h28;
   // field positions
   localparam int CFG_ARM_BIT = 7;
   localparam int CFG_ENDLESS_REPEAT_BIT = 6;
   localparam int CTRL_ON_BIT = 0;
   localparam int STAT_ALARM_BIT = 0;
   localparam int STAT_SECOND_BIT = 1;
   // reset values
   localparam logic [7:0] TRIM_RST = 8'h00;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] RPT_RST = 8'h00;
   localparam logic [1:0] PTR_RST = 2'h0;
   // timing: crystal clock counts per half second, minute length in seconds
   localparam logic [15:0] HALF_SEC_TICKS = 16'h4000;
   localparam logic [5:0] SEC_PER_MIN = 6'h3C;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // interval selections for the digit mask
   typedef enum logic [3:0] {
      MSK_HALF, MSK_SEC, MSK_10SEC, MSK_MIN, MSK_10MIN, MSK_HOUR, MSK_DAY,
      MSK_WEEK, MSK_MONTH, MSK_YEAR
   } rtcca_mask_t;
   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] day;
      logic [7:0] month;
      logic [7:0] weekday;
   } rtcca_time_t;
   typedef struct packed {
      logic awPend;
      logic [7:0] awAddr;
      logic wPend;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } rtcca_bus_t;
endpackage
`default_nettype wire

//--- rtcca_core.sv
// calibration and alarm logic of a real-time clock, with an AXI4-Lite register slave
// Overview of operation
// - window shows an alarm byte pair chosen by a 2-bit pointer; 11 reads zero
// - signed 8-bit trim value, times four, applied to timer count each minute
// - trim count sits in low half of trim register and drives the adjustment
// - negative trim removes pulses from the timer count, positive adds them
// - arm bit clears on alarm unless endless repeat set or repeat count nonzero
// - 4-bit digit mask picks which and how many digits must match the alarm
// - repeating alarms; repetitions after arming held in repeat count register
// - alarm interval selectable from half a second to one year
// - arm bit is bit 7 of alarm config; setting it arms the comparison
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rtcca_core (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic xtalTick,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic alarmIrq,
   output logic secondPulse,
   output logic rolloverPending
);
   import rtcca_pkg::*;

   typedef struct packed {
      rtcca_bus_t bus;
      logic [15:0] trim;
      logic [7:0] cfg;
      logic [7:0] rpt;
      logic [1:0] ptr;
      logic [47:0] alarm;
      rtcca_time_t now;
      logic half;
      logic [15:0] ticks;
      logic [5:0] secInMin;
      logic [1:0] stat;
      logic [1:0] mask;
      logic timerOn;
      logic secPulse;
   } rtcca_state_t;

   rtcca_state_t st_r;
   rtcca_state_t st_nxt;

   // bcd increment with wrap to a low bound
   function automatic logic [7:0] bcdInc(input logic [7:0] v, input logic [7:0] top,
                                         input logic [7:0] low);
      logic [7:0] r;
      r = v;
      if (v >= top) begin
         r = low;
      end else if (v[3:0] == 4'h9) begin
         r = {v[7:4] + 4'h1, 4'h0};
      end else begin
         r = v + 8'h01;
      end
      return r;
   endfunction

   // digit match for the chosen interval, coarser intervals compare at least as many digits
   function automatic logic alarmHit(input logic [3:0] m, input rtcca_time_t t,
                                     input logic [47:0] a, input logic half);
      logic s1;
      logic s10;
      logic mn1;
      logic mn10;
      logic hr;
      logic dy;
      logic wd;
      logic mo;
      s1 = (t.sec[3:0] == a[3:0]);
      s10 = (t.sec[7:4] == a[7:4]);
      mn1 = (t.min[3:0] == a[11:8]);
      mn10 = (t.min[7:4] == a[15:12]);
      hr = (t.hour == a[23:16]);
      wd = (t.weekday == a[31:24]);
      dy = (t.day == a[39:32]);
      mo = (t.month == a[47:40]);
      case (m)
         MSK_HALF: alarmHit = 1'b1;
         MSK_SEC: alarmHit = !half;
         MSK_10SEC: alarmHit = !half && s1;
         MSK_MIN: alarmHit = !half && s1 && s10;
         MSK_10MIN: alarmHit = !half && s1 && s10 && mn1;
         MSK_HOUR: alarmHit = !half && s1 && s10 && mn1 && mn10;
         MSK_DAY: alarmHit = !half && s1 && s10 && mn1 && mn10 && hr;
         MSK_WEEK: alarmHit = !half && s1 && s10 && mn1 && mn10 && hr && wd;
         MSK_MONTH: alarmHit = !half && s1 && s10 && mn1 && mn10 && hr && dy;
         MSK_YEAR: alarmHit = !half && s1 && s10 && mn1 && mn10 && hr && dy && mo;
         default: alarmHit = 1'b0;
      endcase
   endfunction

   logic wrGo;
   logic rdGo;
   logic halfDone;
   logic hit;
   logic [31:0] wd;
   logic [15:0] adj;
   logic [15:0] target;

   assign awready = !st_r.bus.awPend && !st_r.bus.bValid;
   assign wready = !st_r.bus.wPend && !st_r.bus.bValid;
   assign arready = !st_r.bus.rValid;
   assign bvalid = st_r.bus.bValid;
   assign bresp = st_r.bus.bResp;
   assign rvalid = st_r.bus.rValid;
   assign rdata = st_r.bus.rData;
   assign rresp = st_r.bus.rResp;
   assign alarmIrq = |(st_r.stat & st_r.mask);
   assign secondPulse = st_r.secPulse;
   assign rolloverPending = st_r.timerOn && (st_r.ticks >= (target - 16'h0020));

   // minute correction: sign-extended trim times four, stretched or shortened on the
   // last half second of each minute; a positive value shortens it so counts are added
   always_comb begin
      adj = {{6{st_r.trim[7]}}, st_r.trim[7:0], 2'b00};
      if (st_r.secInMin == SEC_PER_MIN - 6'h01 && st_r.half) begin
         target = HALF_SEC_TICKS - adj;
      end else begin
         target = HALF_SEC_TICKS;
      end
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.secPulse = 1'b0;
      wrGo = st_nxt.bus.awPend && st_nxt.bus.wPend;
      wd = st_r.bus.wData;
      halfDone = 1'b0;
      hit = 1'b0;
      // bus channel capture, address and data in either order
      if (awvalid && awready) begin
         st_nxt.bus.awPend = 1'b1;
         st_nxt.bus.awAddr = awaddr;
      end
      if (wvalid && wready) begin
         st_nxt.bus.wPend = 1'b1;
         st_nxt.bus.wData = wdata;
         st_nxt.bus.wStrb = wstrb;
         wd = wdata;
      end
      if (bvalid && bready) begin
         st_nxt.bus.bValid = 1'b0;
      end
      if (rvalid && rready) begin
         st_nxt.bus.rValid = 1'b0;
      end
      // timekeeping from the crystal tick
      if (st_r.timerOn && xtalTick) begin
         if (st_r.ticks + 16'h0001 >= target) begin
            halfDone = 1'b1;
            st_nxt.ticks = 16'h0000;
         end else begin
            st_nxt.ticks = st_r.ticks + 16'h0001;
         end
      end
      if (halfDone) begin
         st_nxt.half = !st_r.half;
         if (st_r.half) begin
            st_nxt.secPulse = 1'b1;
            st_nxt.stat[STAT_SECOND_BIT] = 1'b1;
            st_nxt.secInMin = (st_r.secInMin == SEC_PER_MIN - 6'h01) ? 6'h00
                                                                      : st_r.secInMin + 6'h01;
            st_nxt.now.sec = bcdInc(st_r.now.sec, 8'h59, 8'h00);
            if (st_r.now.sec == 8'h59) begin
               st_nxt.now.min = bcdInc(st_r.now.min, 8'h59, 8'h00);
               if (st_r.now.min == 8'h59) begin
                  st_nxt.now.hour = bcdInc(st_r.now.hour, 8'h23, 8'h00);
                  if (st_r.now.hour == 8'h23) begin
                     st_nxt.now.weekday = bcdInc(st_r.now.weekday, 8'h06, 8'h00);
                     st_nxt.now.day = bcdInc(st_r.now.day, 8'h31, 8'h01);
                     if (st_r.now.day == 8'h31) begin
                        st_nxt.now.month = bcdInc(st_r.now.month, 8'h12, 8'h01);
                     end
                  end
               end
            end
         end
         // alarm compare on each half-second boundary, after the digits advance;
         // the new phase is used so whole-second intervals fire as the second starts
         hit = st_r.cfg[CFG_ARM_BIT] && alarmHit(st_r.cfg[3:0], st_nxt.now, st_r.alarm,
                                                 st_nxt.half);
      end
      if (hit) begin
         st_nxt.stat[STAT_ALARM_BIT] = 1'b1;
         if (st_r.rpt != 8'h00) begin
            st_nxt.rpt = st_r.rpt - 8'h01;
         end else if (!st_r.cfg[CFG_ENDLESS_REPEAT_BIT]) begin
            st_nxt.cfg[CFG_ARM_BIT] = 1'b0;
         end
      end
      // register write once both address and data are held
      wrGo = st_nxt.bus.awPend && st_nxt.bus.wPend && !st_r.bus.bValid;
      if (wrGo) begin
         st_nxt.bus.awPend = 1'b0;
         st_nxt.bus.wPend = 1'b0;
         st_nxt.bus.bValid = 1'b1;
         st_nxt.bus.bResp = RESP_OKAY;
         case (st_nxt.bus.awAddr)
            ADDR_TRIM: begin
               if (st_nxt.bus.wStrb[0]) st_nxt.trim[7:0] = wd[7:0];
               if (st_nxt.bus.wStrb[1]) st_nxt.trim[15:8] = wd[15:8];
            end
            ADDR_CFG: begin
               if (st_nxt.bus.wStrb[0]) st_nxt.cfg = wd[7:0];
            end
            ADDR_RPT: begin
               if (st_nxt.bus.wStrb[0]) st_nxt.rpt = wd[7:0];
            end
            ADDR_PTR: begin
               if (st_nxt.bus.wStrb[0]) st_nxt.ptr = wd[1:0];
            end
            ADDR_WIN: begin
               case (st_r.ptr)
                  2'h0: begin
                     if (st_nxt.bus.wStrb[0]) st_nxt.alarm[7:0] = wd[7:0];
                     if (st_nxt.bus.wStrb[1]) st_nxt.alarm[15:8] = wd[15:8];
                  end
                  2'h1: begin
                     if (st_nxt.bus.wStrb[0]) st_nxt.alarm[23:16] = wd[7:0];
                     if (st_nxt.bus.wStrb[1]) st_nxt.alarm[31:24] = wd[15:8];
                  end
                  2'h2: begin
                     if (st_nxt.bus.wStrb[0]) st_nxt.alarm[39:32] = wd[7:0];
                     if (st_nxt.bus.wStrb[1]) st_nxt.alarm[47:40] = wd[15:8];
                  end
                  default: begin
                  end
               endcase
               st_nxt.ptr = st_r.ptr + 2'h1;
            end
            ADDR_TIME0: begin
               st_nxt.now.sec = wd[7:0];
               st_nxt.now.min = wd[15:8];
               st_nxt.half = 1'b0;
               st_nxt.ticks = 16'h0000;
               // keep the minute count in step with the seconds digits so trim lands on 59
               st_nxt.secInMin = {2'b00, wd[7:4]} * 6'h0A + {2'b00, wd[3:0]};
            end
            ADDR_TIME1: begin
               st_nxt.now.hour = wd[7:0];
               st_nxt.now.weekday = wd[15:8];
            end
            ADDR_TIME2: begin
               st_nxt.now.day = wd[7:0];
               st_nxt.now.month = wd[15:8];
            end
            ADDR_STAT: begin
               // write one to clear, but an event in the same cycle wins when the bit was clear before it
               st_nxt.stat = st_nxt.stat & ~(wd[1:0] & ~(st_nxt.stat & ~st_r.stat));
            end
            ADDR_MASK: st_nxt.mask = wd[1:0];
            ADDR_CTRL: st_nxt.timerOn = wd[CTRL_ON_BIT];
            default: st_nxt.bus.bResp = RESP_SLVERR;
         endcase
      end
      // register read
      if (arvalid && arready) begin
         st_nxt.bus.rValid = 1'b1;
         st_nxt.bus.rResp = RESP_OKAY;
         st_nxt.bus.rData = 32'h0000_0000;
         case (araddr)
            ADDR_TRIM: st_nxt.bus.rData[15:0] = st_r.trim;
            ADDR_CFG: st_nxt.bus.rData[7:0] = st_nxt.cfg;
            ADDR_RPT: st_nxt.bus.rData[7:0] = st_nxt.rpt;
            ADDR_PTR: st_nxt.bus.rData[1:0] = st_r.ptr;
            ADDR_WIN: begin
               case (st_r.ptr)
                  2'h0: st_nxt.bus.rData[15:0] = st_r.alarm[15:0];
                  2'h1: st_nxt.bus.rData[15:0] = st_r.alarm[31:16];
                  2'h2: st_nxt.bus.rData[15:0] = st_r.alarm[47:32];
                  default: st_nxt.bus.rData[15:0] = 16'h0000;
               endcase
               if (!(wrGo && st_nxt.bus.awAddr == ADDR_WIN)) begin
                  st_nxt.ptr = st_r.ptr + 2'h1;
               end
            end
            ADDR_TIME0: st_nxt.bus.rData[15:0] = {st_r.now.min, st_r.now.sec};
            ADDR_TIME1: st_nxt.bus.rData[15:0] = {st_r.now.weekday, st_r.now.hour};
            ADDR_TIME2: st_nxt.bus.rData[15:0] = {st_r.now.month, st_r.now.day};
            ADDR_STAT: st_nxt.bus.rData[1:0] = st_r.stat;
            ADDR_MASK: st_nxt.bus.rData[1:0] = st_r.mask;
            ADDR_CTRL: st_nxt.bus.rData[2:0] = {rolloverPending, st_r.half, st_r.timerOn};
            default: st_nxt.bus.rResp = RESP_SLVERR;
         endcase
      end
   end

   // single state register; async reset loads constants only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
         st_r.trim <= {8'h00, TRIM_RST};
         st_r.cfg <= CFG_RST;
         st_r.rpt <= RPT_RST;
         st_r.ptr <= PTR_RST;
         st_r.now.day <= 8'h01;
         st_r.now.month <= 8'h01;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule
`default_nettype wire

//--- rtcca_core_properties.sv
// bus handshake and timing checks for the calibration and alarm block
`timescale 1ns/1ps
`default_nettype none
module rtcca_core_properties
   import rtcca_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic alarmIrq,
   input wire logic secondPulse
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // answers must stand until the master takes them
   a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response changed before handshake");
   a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable({rresp, rdata}))
      else $error("read answer changed before handshake");
   // answer latency is one cycle after the request is complete
   a_write_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
      else $error("write response late");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   // one transfer of each kind at a time
   a_read_refuse: assert property (rvalid |-> !arready)
      else $error("read accepted while answer pending");
   a_write_refuse: assert property (bvalid |-> !awready && !wready)
      else $error("write accepted while response pending");
   a_rvalid_drop: assert property (rvalid && rready |=> !rvalid)
      else $error("read answer repeated");
   // a second is far longer than eight cycles, so pulses never bunch
   a_pulse_single: assert property (secondPulse |=> !secondPulse [*8])
      else $error("second pulse too long or too close");
   c_write: cover property (bvalid && bready);
   c_slverr: cover property (rvalid && rready && rresp == RESP_SLVERR);
   c_alarm: cover property ($rose(alarmIrq));
endmodule
`default_nettype wire

//--- tb.sv
// self-checking testbench for the calibration and alarm block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import rtcca_pkg::*;
   logic clk = 1'b0;
   logic rst_b, xtalTick, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, alarmIrq, secondPulse, rolloverPending;
   logic [7:0] awaddr, araddr, trimV;
   logic [31:0] wdata, rdata, rnd, expLen;
   logic [31:0] cyc = 32'h0;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [15:0] win [3];
   logic [33:0] expR [$];
   logic [1:0] expB [$];
   logic [31:0] pulseT [$];
   int n_fail = 0;
   int n_checks = 0;
   int rollCnt = 0;
   integer seed = 32'hE723AE21;
   int i;
   int k;
   always #2 clk = ~clk;
   rtcca_core dut (.clk(clk), .rst_b(rst_b), .xtalTick(xtalTick), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .alarmIrq(alarmIrq), .secondPulse(secondPulse),
      .rolloverPending(rolloverPending));
   task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // one register access; the expectation is queued for the monitor
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
         input logic [33:0] e);
      int n;
      logic awT, wT, bT, arT, rT;
      if (wr) expB.push_back(e[33:32]);
      else expR.push_back(e);
      @(posedge clk);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= wr;
      wvalid <= wr;
      arvalid <= !wr;
      n = 0;
      // ready is sampled at the falling edge, where it has settled; the answer is
      // taken one cycle late so the hold checks see a stalled response
      do begin
         @(negedge clk);
         awT = awvalid && awready;
         wT = wvalid && wready;
         bT = bready && bvalid;
         arT = arvalid && arready;
         rT = rready && rvalid;
         @(posedge clk);
         if (awT) awvalid <= 1'b0;
         if (wT) wvalid <= 1'b0;
         if (bT) bready <= 1'b0;
         if (arT) arvalid <= 1'b0;
         if (rT) rready <= 1'b0;
         if (n == 1) begin
            bready <= wr;
            rready <= !wr;
         end
         n++;
      end while (n < 200 && (n < 3 || awvalid || wvalid || bready || arvalid || rready));
      if (n >= 200) begin
         n_fail++;
         final_report();
      end
   endtask
   task automatic waitIrq();
      int n;
      for (n = 0; n < 40000 && alarmIrq !== 1'b1; n++) @(negedge clk);
      if (n >= 40000) begin
         n_fail++;
         final_report();
      end
   endtask
   // monitor: compares each answer with the oldest queued note
   always @(posedge clk) begin
      cyc <= cyc + 32'h1;
      if (rst_b && secondPulse) pulseT.push_back(cyc);
      // cycles flagged near a boundary during the first measured second
      if (rst_b && rolloverPending && pulseT.size() == 1) rollCnt <= rollCnt + 1;
      if (rvalid && rready) chk("read", {rresp, rdata}, expR.pop_front());
      if (bvalid && bready) chk("bresp", {32'h0, bresp}, expB.pop_front());
   end
   initial begin
      rst_b = 1'b0;
      xtalTick = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      bus(1'b0, ADDR_TRIM, 32'h0, {RESP_OKAY, 24'h0, TRIM_RST});
      bus(1'b0, ADDR_CFG, 32'h0, {RESP_OKAY, 24'h0, CFG_RST});
      bus(1'b0, ADDR_RPT, 32'h0, {RESP_OKAY, 24'h0, RPT_RST});
      bus(1'b0, ADDR_PTR, 32'h0, {RESP_OKAY, 30'h0, PTR_RST});
      // unmapped place: refused both ways, reads zero
      bus(1'b1, 8'h30, 32'hFFFFFFFF, {RESP_SLVERR, 32'h0});
      bus(1'b0, 8'h30, 32'h0, {RESP_SLVERR, 32'h0});
      // window walk: three pairs, an empty fourth, then wrap
      bus(1'b1, ADDR_PTR, 32'h0, 34'h0);
      for (i = 0; i < 3; i++) begin
         rnd = $random(seed);
         win[i] = rnd[15:0];
         bus(1'b1, ADDR_WIN, {16'h0, win[i]}, 34'h0);
      end
      bus(1'b0, ADDR_PTR, 32'h0, {RESP_OKAY, 32'h3});
      bus(1'b1, ADDR_WIN, 32'h0000FFFF, 34'h0);
      for (i = 0; i < 4; i++) begin
         bus(1'b0, ADDR_WIN, 32'h0, {RESP_OKAY, 16'h0, (i < 3) ? win[i] : 16'h0});
      end
      bus(1'b0, ADDR_PTR, 32'h0, {RESP_OKAY, 32'h0});
      // every interval code, with the endless bit toggled
      for (i = 0; i < 10; i++) begin
         rnd = {24'h0, 1'b0, i[0], 2'b00, i[3:0]};
         bus(1'b1, ADDR_CFG, rnd, 34'h0);
         bus(1'b0, ADDR_CFG, 32'h0, {RESP_OKAY, rnd});
      end
      // random trim; upper byte is noise that must not count
      rnd = $random(seed);
      trimV = rnd[7:0];
      bus(1'b1, ADDR_TRIM, {16'h0, rnd[15:8], trimV}, 34'h0);
      bus(1'b0, ADDR_TRIM, 32'h0, {RESP_OKAY, 16'h0, rnd[15:8], trimV});
      expLen = 32'h00008000 - ({{24{trimV[7]}}, trimV} << 2);
      bus(1'b1, ADDR_TIME0, 32'h00000058, 34'h0);
      bus(1'b1, ADDR_RPT, 32'h1, 34'h0);
      bus(1'b1, ADDR_MASK, 32'h1, 34'h0);
      bus(1'b1, ADDR_CFG, 32'h00000081, 34'h0);
      bus(1'b1, ADDR_CTRL, 32'h1, 34'h0);
      bus(1'b0, ADDR_CTRL, 32'h0, {RESP_OKAY, 32'h1});
      // one-second interval: first hit on the whole-second edge counts the repeat down
      waitIrq();
      bus(1'b0, ADDR_RPT, 32'h0, {RESP_OKAY, 32'h0});
      chk("alarm on second edge", {2'b0, pulseT.size()}, 34'h1);
      bus(1'b0, ADDR_CFG, 32'h0, {RESP_OKAY, 32'h81});
      bus(1'b1, ADDR_STAT, 32'h1, 34'h0);
      @(negedge clk);
      chk("irq cleared", {33'h0, alarmIrq}, 34'h0);
      // second hit disarms; masking hides the still-set flag
      waitIrq();
      bus(1'b0, ADDR_CFG, 32'h0, {RESP_OKAY, 32'h1});
      bus(1'b1, ADDR_MASK, 32'h0, 34'h0);
      @(negedge clk);
      chk("irq masked", {33'h0, alarmIrq}, 34'h0);
      bus(1'b1, ADDR_STAT, 32'h1, 34'h0);
      // endless repeat keeps a half-second alarm armed with no repeats left
      bus(1'b1, ADDR_MASK, 32'h1, 34'h0);
      bus(1'b1, ADDR_CFG, 32'h000000C0, 34'h0);
      waitIrq();
      bus(1'b0, ADDR_CFG, 32'h0, {RESP_OKAY, 32'hC0});
      // last second of the minute carries the trim
      for (k = 0; k < 70000 && pulseT.size() < 2; k++) @(negedge clk);
      if (pulseT.size() < 2) n_fail++;
      else chk("second length", {2'b0, pulseT[1] - pulseT[0]}, {2'b0, expLen});
      chk("rollover cycles", {2'b0, rollCnt}, 34'h40);
      final_report();
   end
endmodule
bind rtcca_core rtcca_core_properties u_prop (.clk(clk), .rst_b(rst_b), .awvalid(awvalid),
   .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
   .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
   .rvalid(rvalid), .rready(rready), .alarmIrq(alarmIrq), .secondPulse(secondPulse));
`default_nettype wire
